// ==== common/tmr_map.svh ====
// register offsets, bit positions and fixed values of the timer0 block
// assumes inclusion by bare name from the design files
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
// ==========================================================
// port-style addresses
`define TMR_ADR_SFC 8'h20
`define TMR_ADR_ACS 8'h30
`define TMR_ADR_CMP 8'h31
`define TMR_ADR_CNT 8'h32
`define TMR_ADR_CTL 8'h33
`define TMR_ADR_FLG 8'h36
`define TMR_ADR_MSK 8'h37
`define TMR_DATA_OFS 8'h20
// ==========================================================
// bit positions
`define TMR_B_ASYNC 3
`define TMR_B_CNT_BUSY 2
`define TMR_B_CMP_BUSY 1
`define TMR_B_CTL_BUSY 0
`define TMR_B_CMP 1
`define TMR_B_OVF 0
`define TMR_B_SYNC 7
`define TMR_B_TIMER_PRESCALER_RESET 1
`define TMR_B_PSR_SH 0
`define TMR_B_WGM1 6
`define TMR_B_WGM0 3
`define TMR_B_COM1 5
`define TMR_B_COM0 4
`define TMR_B_FOC 7
// ==========================================================
// values
`define TMR_RST 8'h00
`define TMR_MAX 8'hFF
`define TMR_BOTTOM 8'h00
`define TMR_PRE_W 10
`endif

// ==== common/tmr_pkg.sv ====
// types shared by the timer0 register block
// assumes nothing beyond a SystemVerilog compiler
package tmr_pkg;
    typedef logic [7:0] tmr_byte_t;
    typedef enum logic [1:0] {
        TMR_NORMAL,
        TMR_PHASE_PWM,
        TMR_CTC,
        TMR_FAST_PWM
    } tmr_wave_e;
endpackage

// ==== testbench/tmr_cpu_model.sv ====
// behavioural cpu core on the timer0 I/O register port
// assumes tasks are called one at a time by the bench
`timescale 1ns/1ps
`default_nettype none
module tmr_cpu_model
    import tmr_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] io_addr,
    output logic io_data_space,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // interrupt side
    output logic global_irq_en,
    output logic compare_irq_ack,
    output logic overflow_irq_ack
);
    initial begin
        {io_addr, io_wdata} = 16'h0000;
        {io_data_space, io_wr, io_rd} = 3'h0;
        {global_irq_en, compare_irq_ack, overflow_irq_ack} = 3'h0;
    end
    task automatic put(input logic [7:0] a, input logic ds);
        @(posedge clk_sys);
        #1;
        io_addr = ds ? a + 8'h20 : a;
        io_data_space = ds;
    endtask
    // released lines show the inverse, never a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic ds = 1'b0);
        put(a, ds);
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        io_wr = 1'b0;
        io_wdata = ~d;
        io_addr = ~io_addr;
    endtask
    task automatic rd(input logic [7:0] a, input logic ds,
                      output logic [7:0] d);
        put(a, ds);
        io_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        io_rd = 1'b0;
        io_addr = ~io_addr;
        @(posedge clk_sys);
        #1;
        d = io_rdata;
    endtask
    task automatic ack(input logic ovf);
        @(posedge clk_sys);
        #1;
        compare_irq_ack = !ovf;
        overflow_irq_ack = ovf;
        @(posedge clk_sys);
        #1;
        {compare_irq_ack, overflow_irq_ack} = 2'h0;
    endtask
    task automatic glob(input logic v);
        global_irq_en = v;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tmr_timer0_regs_props.sv ====
// assertions on the ports of the timer0 register block
// assumes bind onto tmr_timer0_regs; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module tmr_timer0_regs_props
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // register port
    input wire logic [7:0] io_addr,
    input wire logic io_data_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // pins and interrupt side
    input wire logic osc_input_pin,
    input wire logic global_irq_en,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic compare_irq_req,
    input wire logic overflow_irq_req,
    input wire logic compare_output_pin,
    input wire logic shared_prescaler_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic wr_sfc;
    logic wr_msk;
    assign wr_sfc = clk_en && io_wr && !io_data_space && io_addr == 8'h20;
    assign wr_msk = clk_en && io_wr && !io_data_space && io_addr == 8'h37;
    // ==========================================================
    // interrupt requests
    property p_cmp_glob;
        compare_irq_req |-> $past(global_irq_en);
    endproperty
    a_cmp_glob: assert property (p_cmp_glob)
        else $error("compare request without global bit");
    property p_ovf_glob;
        overflow_irq_req |-> $past(global_irq_en);
    endproperty
    a_ovf_glob: assert property (p_ovf_glob)
        else $error("overflow request without global bit");
    property p_cmp_mask;
        wr_msk && !io_wdata[1] |-> ##2 !compare_irq_req;
    endproperty
    a_cmp_mask: assert property (p_cmp_mask)
        else $error("compare request survives mask clear");
    property p_ovf_mask;
        wr_msk && !io_wdata[0] |-> ##2 !overflow_irq_req;
    endproperty
    a_ovf_mask: assert property (p_ovf_mask)
        else $error("overflow request survives mask clear");
    // ==========================================================
    // register reads
    property p_unmapped;
        clk_en && io_rd && !io_data_space && io_addr == 8'h3F
            |=> io_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rd_hold;
        !(clk_en && io_rd) |=> $stable(io_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    // ==========================================================
    // prescaler reset hold
    property p_hold;
        wr_sfc && io_wdata[7] && io_wdata[0]
            |-> ##[1:2] shared_prescaler_reset;
    endproperty
    a_hold: assert property (p_hold)
        else $error("shared prescaler reset not held");
    property p_release;
        wr_sfc && !io_wdata[7] |-> ##[1:3] !shared_prescaler_reset;
    endproperty
    a_release: assert property (p_release)
        else $error("shared prescaler reset not released");
    c_cmp_req: cover property (compare_irq_req);
    c_ovf_req: cover property (overflow_irq_req);
    c_held: cover property (shared_prescaler_reset [*3]);
endmodule
bind tmr_timer0_regs tmr_timer0_regs_props u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .io_addr(io_addr), .io_data_space(io_data_space), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .osc_input_pin(osc_input_pin), .global_irq_en(global_irq_en),
    .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
    .compare_output_pin(compare_output_pin),
    .shared_prescaler_reset(shared_prescaler_reset)
);
`default_nettype wire

// ==== testbench/tmr_timer0_regs_tb.sv ====
// self-checking bench for the timer0 register block
// assumes the cpu model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
module tmr_timer0_regs_tb;
    import tmr_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic osc_input_pin = 1'b0;
    logic clk_en = 1'b1;
    wire logic [7:0] io_addr, io_wdata, io_rdata;
    wire logic io_data_space, io_wr, io_rd, global_irq_en;
    wire logic compare_irq_ack, overflow_irq_ack;
    wire logic compare_irq_req, overflow_irq_req, shared_prescaler_reset;
    wire logic compare_output_pin;
    int bad_count = 0;
    int n_tests = 0;
    tmr_timer0_regs u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .io_addr(io_addr), .io_data_space(io_data_space), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .osc_input_pin(osc_input_pin), .global_irq_en(global_irq_en),
        .compare_irq_ack(compare_irq_ack),
        .overflow_irq_ack(overflow_irq_ack),
        .compare_irq_req(compare_irq_req),
        .overflow_irq_req(overflow_irq_req),
        .compare_output_pin(compare_output_pin),
        .shared_prescaler_reset(shared_prescaler_reset)
    );
    tmr_cpu_model u_cpu (
        .clk_sys(clk_sys), .io_addr(io_addr), .io_data_space(io_data_space),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .global_irq_en(global_irq_en),
        .compare_irq_ack(compare_irq_ack),
        .overflow_irq_ack(overflow_irq_ack)
    );
    always #12.5 clk_sys = ~clk_sys;
    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic ds,
                         input logic [7:0] exp);
        logic [7:0] d;
        u_cpu.rd(a, ds, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic osc_pulse();
        osc_input_pin = 1'b1;
        cyc(4);
        osc_input_pin = 1'b0;
        cyc(8);
    endtask
    // counter parked at 0xFE, run a few ticks at full rate, then stop
    task automatic run(input logic [7:0] cmp);
        u_cpu.wr(8'h31, cmp);
        u_cpu.wr(8'h32, 8'hFE);
        u_cpu.wr(8'h33, 8'h11);
        cyc(6);
        u_cpu.wr(8'h33, 8'h00);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] adr [5] = '{8'h20, 8'h30, 8'h31, 8'h36, 8'h37};
        foreach (adr[i]) rdchk(adr[i], 1'b0, 8'h00);
        rdchk(8'h3F, 1'b0, 8'h00);
        $display("end reset values");
    endtask
    task automatic t_compare();
        u_cpu.wr(8'h31, 8'hA5);
        rdchk(8'h31, 1'b1, 8'hA5);
        u_cpu.wr(8'h31, 8'h5A, 1'b1);
        rdchk(8'h31, 1'b0, 8'h5A);
        // a frozen block ignores the write
        clk_en = 1'b0;
        u_cpu.wr(8'h31, 8'h77);
        clk_en = 1'b1;
        rdchk(8'h31, 1'b0, 8'h5A);
        $display("end compare access");
    endtask
    task automatic t_flags();
        run(8'hFE);
        rdchk(8'h36, 1'b0, 8'h01);
        chk("oc pin", {7'h00, compare_output_pin}, 8'h00);
        u_cpu.wr(8'h36, 8'h03);
        rdchk(8'h36, 1'b0, 8'h00);
        run(8'hFF);
        rdchk(8'h36, 1'b0, 8'h03);
        chk("oc pin", {7'h00, compare_output_pin}, 8'h01);
        chk("cmp req", {7'h00, compare_irq_req}, 8'h00);
        u_cpu.glob(1'b1);
        u_cpu.wr(8'h37, 8'h03);
        cyc(2);
        chk("cmp req", {7'h00, compare_irq_req}, 8'h01);
        chk("ovf req", {7'h00, overflow_irq_req}, 8'h01);
        u_cpu.ack(1'b0);
        rdchk(8'h36, 1'b0, 8'h01);
        chk("cmp req", {7'h00, compare_irq_req}, 8'h00);
        u_cpu.wr(8'h36, 8'h01);
        rdchk(8'h36, 1'b0, 8'h00);
        u_cpu.wr(8'h37, 8'h00);
        u_cpu.glob(1'b0);
        // phase pwm: overflow only on the turn at zero
        u_cpu.wr(8'h32, 8'hFE);
        u_cpu.wr(8'h33, 8'h09);
        cyc(4);
        rdchk(8'h36, 1'b0, 8'h02);
        cyc(252);
        u_cpu.wr(8'h33, 8'h00);
        rdchk(8'h36, 1'b0, 8'h03);
        u_cpu.ack(1'b1);
        rdchk(8'h36, 1'b0, 8'h02);
        $display("end flags");
    endtask
    task automatic t_async();
        u_cpu.wr(8'h32, 8'h5C);
        u_cpu.wr(8'h30, 8'h08);
        rdchk(8'h30, 1'b0, 8'h08);
        u_cpu.wr(8'h31, 8'h3C);
        rdchk(8'h30, 1'b0, 8'h0A);
        u_cpu.wr(8'h32, 8'h00);
        rdchk(8'h30, 1'b0, 8'h0E);
        rdchk(8'h32, 1'b0, 8'h5C);
        u_cpu.wr(8'h33, 8'h00);
        rdchk(8'h30, 1'b0, 8'h0F);
        osc_pulse();
        // no rewrite until every busy bit has dropped
        rdchk(8'h30, 1'b0, 8'h08);
        rdchk(8'h31, 1'b0, 8'h3C);
        rdchk(8'h32, 1'b0, 8'h00);
        // timer prescaler reset waits for an oscillator edge
        u_cpu.wr(8'h20, 8'h02);
        rdchk(8'h20, 1'b0, 8'h02);
        osc_pulse();
        rdchk(8'h20, 1'b0, 8'h00);
        u_cpu.wr(8'h30, 8'h00);
        // contents are suspect after a source change
        u_cpu.wr(8'h31, 8'h00);
        u_cpu.wr(8'h33, 8'h00);
        $display("end async");
    endtask
    task automatic t_hold();
        u_cpu.wr(8'h20, 8'h83);
        cyc(4);
        chk("psr hold", {7'h00, shared_prescaler_reset}, 8'h01);
        u_cpu.wr(8'h20, 8'h00);
        cyc(2);
        chk("psr free", {7'h00, shared_prescaler_reset}, 8'h00);
        u_cpu.wr(8'h20, 8'h02);
        rdchk(8'h20, 1'b0, 8'h00);
        $display("end sync hold");
    endtask
    initial begin
        cyc(2);
        reset_n = 1'b1;
        t_reset();
        t_compare();
        t_flags();
        t_async();
        t_hold();
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// ==== verilog/tmr_prescaler.sv ====
// prescaler that turns source ticks into timer ticks
// assumes src_tick is high for one clk_sys cycle per source tick, or held high to count every cycle
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_prescaler
    import tmr_pkg::*;
#(
    parameter int DIV_W = `TMR_PRE_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // control
    input wire logic src_tick,
    input wire logic clear,
    input wire logic [2:0] sel,
    // result
    output logic tick
);
    generate
        if (DIV_W < `TMR_PRE_W) begin : g_bad_width
            $error("tmr_prescaler: DIV_W too small");
        end
    endgenerate

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic [DIV_W-1:0] mask;

    // ==========================================================
    // divide select
    always_comb begin
        case (sel)
            3'h1: mask = DIV_W'(0);
            3'h2: mask = DIV_W'(7);
            3'h3: mask = DIV_W'(31);
            3'h4: mask = DIV_W'(63);
            3'h5: mask = DIV_W'(127);
            3'h6: mask = DIV_W'(255);
            3'h7: mask = DIV_W'(1023);
            default: mask = DIV_W'(0);
        endcase
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = '0;
        end else if (src_tick) begin
            cnt_d = cnt_q + DIV_W'(1);
        end
        // a held reset stops the timer outright
        tick = src_tick && !clear && (sel != 3'h0)
            && ((cnt_q & mask) == mask);
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/tmr_timer0_regs.sv ====
// timer0 register side: compare, async select, flags, sync hold mode
// assumes one cpu access per cycle on the I/O register port
//
// What this block does
// - 8-bit compare value, matched against counter continuously
// - async select bit picks I/O or oscillator clock
// - async counter write sets counter busy until loaded
// - async compare write sets compare busy until loaded
// - async control write sets control busy until loaded
// - counter reads live; compare/control read holding copy
// - compare flag, enable, global bit request interrupt
// - overflow flag, enable, global bit request interrupt
// - compare flag set on counter-compare match
// - compare flag cleared by vector or written one
// - overflow flag set on overflow, cleared likewise
// - phase PWM sets overflow when reversing at zero
// - sync hold mode keeps prescaler reset bits set
// - leaving sync hold clears both prescaler resets
// - port address, or port address plus 0x20
// - prescaler reset self-clears, async once reset done
// - counter write blocks match on next timer tick
`timescale 1ns/1ps
`default_nettype none
`include "tmr_map.svh"
module tmr_timer0_regs
    import tmr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // I/O register port
    input wire logic [7:0] io_addr,
    input wire logic io_data_space,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // oscillator pin
    input wire logic osc_input_pin,
    // interrupt side
    input wire logic global_irq_en,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    output logic compare_irq_req,
    output logic overflow_irq_req,
    // pins and neighbours
    output logic compare_output_pin,
    output logic shared_prescaler_reset
);
    // ==========================================================
    // state
    tmr_byte_t cnt_q, cnt_d, cnt_hold_q, cnt_hold_d;
    tmr_byte_t cmp_q, cmp_d, cmp_hold_q, cmp_hold_d;
    tmr_byte_t ctl_q, ctl_d, ctl_hold_q, ctl_hold_d;
    tmr_byte_t rdata_q, rdata_d;
    logic async_q, async_d;
    logic cnt_busy_q, cnt_busy_d, cmp_busy_q, cmp_busy_d;
    logic ctl_busy_q, ctl_busy_d;
    logic [1:0] mask_q, mask_d;
    logic cmpf_q, cmpf_d, ovf_q, ovf_d;
    logic sync_q, sync_d, timer_prescaler_reset_q, timer_prescaler_reset_d, psr_sh_q, psr_sh_d;
    logic down_q, down_d, block_q, block_d, oc_q, oc_d;
    logic cmp_req_q, cmp_req_d, ovf_req_q, ovf_req_d;
    logic osc_s1_q, osc_s2_q, osc_s3_q;

    // ==========================================================
    // decode
    tmr_byte_t eff_addr;
    logic addr_ok, wr, rd, src_tick, tmr_tick, match;
    logic ovf_set;
    tmr_wave_e wave;

    always_comb begin
        eff_addr = io_data_space ? io_addr - `TMR_DATA_OFS : io_addr;
        addr_ok = !io_data_space || (io_addr >= `TMR_DATA_OFS);
        wr = io_wr && addr_ok;
        rd = io_rd && addr_ok;
        // oscillator edges only after two-stage sync
        src_tick = async_q ? (osc_s2_q && !osc_s3_q) : 1'b1;
        match = (cnt_q == cmp_q);
        case ({ctl_q[`TMR_B_WGM1], ctl_q[`TMR_B_WGM0]})
            2'b01: wave = TMR_PHASE_PWM;
            2'b10: wave = TMR_CTC;
            2'b11: wave = TMR_FAST_PWM;
            default: wave = TMR_NORMAL;
        endcase
    end

    tmr_prescaler #(
        .DIV_W(`TMR_PRE_W)
    ) u_pre (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .src_tick(src_tick),
        .clear(timer_prescaler_reset_q),
        .sel(ctl_q[2:0]),
        .tick(tmr_tick)
    );

    // ==========================================================
    // register writes and transfers
    always_comb begin
        cnt_hold_d = cnt_hold_q;
        cmp_hold_d = cmp_hold_q;
        ctl_hold_d = ctl_hold_q;
        cmp_d = cmp_q;
        ctl_d = ctl_q;
        async_d = async_q;
        cnt_busy_d = cnt_busy_q;
        cmp_busy_d = cmp_busy_q;
        ctl_busy_d = ctl_busy_q;
        mask_d = mask_q;
        sync_d = sync_q;
        timer_prescaler_reset_d = timer_prescaler_reset_q;
        psr_sh_d = psr_sh_q;
        // transfers wait for an oscillator edge
        if (async_q && src_tick) begin
            if (cmp_busy_q) begin
                cmp_d = cmp_hold_q;
                cmp_busy_d = 1'b0;
            end
            if (ctl_busy_q) begin
                ctl_d = ctl_hold_q;
                ctl_busy_d = 1'b0;
            end
            if (cnt_busy_q) begin
                cnt_busy_d = 1'b0;
            end
        end
        // prescaler reset self-clears unless held
        if (!sync_q) begin
            if (!async_q || src_tick) begin
                timer_prescaler_reset_d = 1'b0;
            end
            psr_sh_d = 1'b0;
        end
        if (wr) begin
            case (eff_addr)
                `TMR_ADR_CMP: begin
                    cmp_hold_d = io_wdata;
                    if (async_q) begin
                        cmp_busy_d = 1'b1;
                    end else begin
                        cmp_d = io_wdata;
                    end
                end
                `TMR_ADR_CTL: begin
                    ctl_hold_d = io_wdata;
                    if (async_q) begin
                        ctl_busy_d = 1'b1;
                    end else begin
                        ctl_d = io_wdata;
                    end
                end
                `TMR_ADR_CNT: begin
                    cnt_hold_d = io_wdata;
                    if (async_q) begin
                        cnt_busy_d = 1'b1;
                    end
                end
                `TMR_ADR_ACS: begin
                    async_d = io_wdata[`TMR_B_ASYNC];
                end
                `TMR_ADR_MSK: begin
                    mask_d = {io_wdata[`TMR_B_CMP], io_wdata[`TMR_B_OVF]};
                end
                `TMR_ADR_SFC: begin
                    sync_d = io_wdata[`TMR_B_SYNC];
                    if (io_wdata[`TMR_B_TIMER_PRESCALER_RESET]) begin
                        timer_prescaler_reset_d = 1'b1;
                    end
                    if (io_wdata[`TMR_B_PSR_SH]) begin
                        psr_sh_d = 1'b1;
                    end
                    if (!io_wdata[`TMR_B_SYNC] && sync_q) begin
                        // all halted timers restart together
                        timer_prescaler_reset_d = 1'b0;
                        psr_sh_d = 1'b0;
                    end else if (io_wdata[`TMR_B_SYNC]) begin
                        timer_prescaler_reset_d = timer_prescaler_reset_d | timer_prescaler_reset_q;
                        psr_sh_d = psr_sh_d | psr_sh_q;
                    end
                end
                default: begin
                end
            endcase
        end
        // the strobe bit is never stored
        ctl_hold_d[`TMR_B_FOC] = 1'b0;
        ctl_d[`TMR_B_FOC] = 1'b0;
    end

    // ==========================================================
    // counter, compare and flags
    always_comb begin
        cnt_d = cnt_q;
        down_d = down_q;
        block_d = block_q;
        oc_d = oc_q;
        cmpf_d = cmpf_q;
        ovf_d = ovf_q;
        ovf_set = 1'b0;
        if (tmr_tick) begin
            block_d = 1'b0;
            if (match && !block_q) begin
                cmpf_d = 1'b1;
                case ({ctl_q[`TMR_B_COM1], ctl_q[`TMR_B_COM0]})
                    2'b01: oc_d = !oc_q;
                    2'b10: oc_d = 1'b0;
                    2'b11: oc_d = 1'b1;
                    default: oc_d = oc_q;
                endcase
            end
            case (wave)
                TMR_PHASE_PWM: begin
                    if (!down_q) begin
                        down_d = (cnt_q == `TMR_MAX);
                        cnt_d = down_d ? cnt_q - 8'h01 : cnt_q + 8'h01;
                    end else if (cnt_q == `TMR_BOTTOM) begin
                        down_d = 1'b0;
                        ovf_set = 1'b1;
                        cnt_d = cnt_q + 8'h01;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                TMR_CTC: begin
                    cnt_d = match ? `TMR_BOTTOM : cnt_q + 8'h01;
                    ovf_set = (cnt_q == `TMR_MAX);
                end
                default: begin
                    cnt_d = cnt_q + 8'h01;
                    ovf_set = (cnt_q == `TMR_MAX);
                end
            endcase
        end
        // a cpu load outranks counting and masks the next match
        if (wr && eff_addr == `TMR_ADR_CNT && !async_q) begin
            cnt_d = io_wdata;
            block_d = 1'b1;
        end else if (async_q && src_tick && cnt_busy_q) begin
            cnt_d = cnt_hold_q;
            block_d = 1'b1;
        end
        ovf_d = ovf_q | ovf_set;
        // a set in the same cycle as a clear wins
        if (wr && eff_addr == `TMR_ADR_FLG) begin
            if (io_wdata[`TMR_B_CMP] && !(tmr_tick && match && !block_q)) begin
                cmpf_d = 1'b0;
            end
            if (io_wdata[`TMR_B_OVF] && !ovf_set) begin
                ovf_d = 1'b0;
            end
        end
        if (compare_irq_ack && !(tmr_tick && match && !block_q)) begin
            cmpf_d = 1'b0;
        end
        if (overflow_irq_ack && !ovf_set) begin
            ovf_d = 1'b0;
        end
        cmp_req_d = cmpf_q && mask_q[1] && global_irq_en;
        ovf_req_d = ovf_q && mask_q[0] && global_irq_en;
    end

    // ==========================================================
    // read port
    always_comb begin
        rdata_d = rdata_q;
        if (rd) begin
            case (eff_addr)
                `TMR_ADR_CNT: rdata_d = cnt_q;
                `TMR_ADR_CMP: rdata_d = cmp_hold_q;
                `TMR_ADR_CTL: rdata_d = ctl_hold_q;
                `TMR_ADR_ACS: rdata_d = {4'h0, async_q, cnt_busy_q,
                    cmp_busy_q, ctl_busy_q};
                `TMR_ADR_FLG: rdata_d = {6'h00, cmpf_q, ovf_q};
                `TMR_ADR_MSK: rdata_d = {6'h00, mask_q};
                // reset bit reads zero on the I/O clock
                `TMR_ADR_SFC: rdata_d = {sync_q, 5'h00,
                    timer_prescaler_reset_q && async_q, psr_sh_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_q <= `TMR_RST;
            cnt_hold_q <= `TMR_RST;
            cmp_q <= `TMR_RST;
            cmp_hold_q <= `TMR_RST;
            ctl_q <= `TMR_RST;
            ctl_hold_q <= `TMR_RST;
            rdata_q <= `TMR_RST;
            async_q <= 1'b0;
            cnt_busy_q <= 1'b0;
            cmp_busy_q <= 1'b0;
            ctl_busy_q <= 1'b0;
            mask_q <= 2'h0;
            cmpf_q <= 1'b0;
            ovf_q <= 1'b0;
            sync_q <= 1'b0;
            timer_prescaler_reset_q <= 1'b0;
            psr_sh_q <= 1'b0;
            down_q <= 1'b0;
            block_q <= 1'b0;
            oc_q <= 1'b0;
            cmp_req_q <= 1'b0;
            ovf_req_q <= 1'b0;
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else if (clk_en) begin
            cnt_q <= cnt_d;
            cnt_hold_q <= cnt_hold_d;
            cmp_q <= cmp_d;
            cmp_hold_q <= cmp_hold_d;
            ctl_q <= ctl_d;
            ctl_hold_q <= ctl_hold_d;
            rdata_q <= rdata_d;
            async_q <= async_d;
            cnt_busy_q <= cnt_busy_d;
            cmp_busy_q <= cmp_busy_d;
            ctl_busy_q <= ctl_busy_d;
            mask_q <= mask_d;
            cmpf_q <= cmpf_d;
            ovf_q <= ovf_d;
            sync_q <= sync_d;
            timer_prescaler_reset_q <= timer_prescaler_reset_d;
            psr_sh_q <= psr_sh_d;
            down_q <= down_d;
            block_q <= block_d;
            oc_q <= oc_d;
            cmp_req_q <= cmp_req_d;
            ovf_req_q <= ovf_req_d;
            osc_s1_q <= osc_input_pin;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign io_rdata = rdata_q;
    assign compare_irq_req = cmp_req_q;
    assign overflow_irq_req = ovf_req_q;
    assign compare_output_pin = oc_q;
    assign shared_prescaler_reset = psr_sh_q;
endmodule
`default_nettype wire
